// File: ast_uart.sv
// Chosen here: the APB slave port and the placing of the registers.
`include "ast_defs.svh"
`default_nettype none
module ast_uart #(
	parameter int DIV_W = 8
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device side
	input wire logic sleep_mode,
	input wire logic rx_pin,
	output logic tx_pin,
	output logic irq_request
);
	import ast_pkg::*;

	if (DIV_W < 1 || DIV_W > 8) begin : g_chk
		$error("ast_uart: DIV_W must be 1 to 8");
	end

	// ==========================================
	// declarations
	logic [7:0] interrupt_control;
	logic [7:0] peripheral_flags_1_other;
	logic [7:0] peripheral_enables_1;
	logic [7:0] peripheral_priorities_1;
	logic [7:0] peripheral_flags_3;
	logic [7:0] peripheral_enables_3;
	logic [7:0] peripheral_priorities_3;
	logic [7:0] txbuf;
	logic [7:0] baud;
	logic [7:0] rxdata;
	ast_txsta_t txsta;
	ast_rcsta_t rcsta;
	ast_txsta_t txsta_rd;
	ast_rcsta_t rcsta_rd;
	logic [7:0] rd_mux;
	logic hit;
	logic apb_wr;
	logic apb_rd;
	logic wr_tx;
	logic rd_rx;
	logic tx_flag;
	logic rc_flag;
	logic clr_pend;
	logic transmit_enable_q;
	logic buf_full;
	logic framing_error;
	logic overrun_error;
	logic received_ninth_bit;
	logic port_on;
	logic tx_on;
	logic rx_on;
	logic [DIV_W-1:0] brg_cnt;
	logic brg_tick;
	logic [1:0] pre;
	logic s16;
	logic load_tx;
	logic tx_busy;
	logic [10:0] tx_shift;
	logic [3:0] tx_bits;
	logic [3:0] tx_ph;
	logic rx_s1;
	logic rx_s2;
	logic rx_s3;
	logic rx_lvl;
	ast_rx_state_t rx_state;
	logic [3:0] rx_ph;
	logic [3:0] rx_cnt;
	logic [8:0] rx_sh;
	logic rx_done;
	logic rx_over;

	// ==========================================
	// apb decode
	assign apb_wr = psel & penable & pready & pwrite;
	assign apb_rd = psel & penable & pready & ~pwrite;
	assign wr_tx = apb_wr & (paddr == `AST_OFF_TXBUF);
	assign rd_rx = apb_rd & (paddr == `AST_OFF_RXDATA);

	// reserved bit reads zero, shifter empty is live state
	always_comb begin
		txsta_rd = txsta;
		txsta_rd.resv = 1'b0;
		txsta_rd.shifter_empty = ~tx_busy;
		rcsta_rd = rcsta;
		rcsta_rd.framing_error = framing_error;
		rcsta_rd.overrun_error = overrun_error;
		rcsta_rd.received_ninth_bit = received_ninth_bit;
	end

	always_comb begin
		hit = 1'b1;
		case (paddr)
			`AST_OFF_INTERRUPT_CONTROL: rd_mux = interrupt_control;
			`AST_OFF_PERIPHERAL_FLAGS_1: begin
				rd_mux = peripheral_flags_1_other;
				rd_mux[`AST_BIT_RCF] = rc_flag;
				rd_mux[`AST_BIT_TXF] = tx_flag;
			end
			`AST_OFF_PERIPHERAL_ENABLES_1: rd_mux = peripheral_enables_1;
			`AST_OFF_PERIPHERAL_PRIORITIES_1: rd_mux = peripheral_priorities_1;
			`AST_OFF_PERIPHERAL_FLAGS_3: rd_mux = peripheral_flags_3;
			`AST_OFF_PERIPHERAL_ENABLES_3: rd_mux = peripheral_enables_3;
			`AST_OFF_PERIPHERAL_PRIORITIES_3: rd_mux = peripheral_priorities_3;
			`AST_OFF_RCSTA: rd_mux = rcsta_rd;
			`AST_OFF_TXBUF: rd_mux = txbuf;
			`AST_OFF_TXSTA: rd_mux = txsta_rd;
			`AST_OFF_BAUD: rd_mux = baud;
			`AST_OFF_RXDATA: rd_mux = rxdata;
			default: begin
				rd_mux = `AST_RST_ZERO;
				hit = 1'b0;
			end
		endcase
	end

	// one wait-free access phase; ready registered from the setup cycle, high in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			if (psel & ~penable) begin
				prdata <= {24'h0, rd_mux};
				pslverr <= ~hit;
			end
		end
	end

	// ==========================================
	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_control <= `AST_RST_ZERO;
			peripheral_flags_1_other <= `AST_RST_ZERO;
			peripheral_enables_1 <= `AST_RST_ZERO;
			peripheral_priorities_1 <= `AST_RST_PERIPHERAL_PRIORITIES_1;
			peripheral_flags_3 <= `AST_RST_ZERO;
			peripheral_enables_3 <= `AST_RST_ZERO;
			peripheral_priorities_3 <= `AST_RST_PERIPHERAL_PRIORITIES_3;
			baud <= `AST_RST_ZERO;
			txsta <= ast_txsta_t'(`AST_RST_TXSTA);
			rcsta <= ast_rcsta_t'(`AST_RST_ZERO);
		end else if (apb_wr) begin
			case (paddr)
				`AST_OFF_INTERRUPT_CONTROL: interrupt_control <= pwdata[7:0];
				`AST_OFF_PERIPHERAL_FLAGS_1: begin
					// flag bits of this port stay hardware owned
					peripheral_flags_1_other <= pwdata[7:0];
					peripheral_flags_1_other[`AST_BIT_RCF] <= 1'b0;
					peripheral_flags_1_other[`AST_BIT_TXF] <= 1'b0;
				end
				`AST_OFF_PERIPHERAL_ENABLES_1: peripheral_enables_1 <= pwdata[7:0];
				`AST_OFF_PERIPHERAL_PRIORITIES_1: peripheral_priorities_1 <= pwdata[7:0];
				`AST_OFF_PERIPHERAL_FLAGS_3: peripheral_flags_3 <= pwdata[7:0] & `AST_PERIPHERAL_FLAGS_3_MASK;
				`AST_OFF_PERIPHERAL_ENABLES_3: peripheral_enables_3 <= pwdata[7:0] & `AST_PERIPHERAL_FLAGS_3_MASK;
				`AST_OFF_PERIPHERAL_PRIORITIES_3: peripheral_priorities_3 <= pwdata[7:0] & `AST_PERIPHERAL_FLAGS_3_MASK;
				`AST_OFF_BAUD: baud <= pwdata[7:0];
				`AST_OFF_TXSTA: txsta <= ast_txsta_t'(pwdata[7:0]);
				`AST_OFF_RCSTA: rcsta <= ast_rcsta_t'(pwdata[7:0]);
				default: begin
				end
			endcase
		end
	end

	// ==========================================
	// baud generator
	assign port_on = rcsta.port_enable & ~txsta.sync;
	assign tx_on = port_on & txsta.transmit_enable;
	assign rx_on = port_on & rcsta.continuous_receive_enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brg_cnt <= '0;
			brg_tick <= 1'b0;
		end else if (!port_on) begin
			brg_cnt <= '0;
			brg_tick <= 1'b0;
		end else if (sleep_mode) begin
			brg_tick <= 1'b0;
		end else if (brg_cnt == '0) begin
			brg_cnt <= baud[DIV_W-1:0];
			brg_tick <= 1'b1;
		end else begin
			brg_cnt <= brg_cnt - 1'b1;
			brg_tick <= 1'b0;
		end
	end

	// low speed ticks run 64x; every fourth one gives the 16x sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre <= 2'h0;
		end else if (!port_on) begin
			pre <= 2'h0;
		end else if (brg_tick & ~sleep_mode) begin
			pre <= pre + 2'h1;
		end
	end

	assign s16 = brg_tick & ~sleep_mode & (txsta.high_speed_select | (pre == `AST_SLOW_PRE));

	// ==========================================
	// transmit buffer and flag
	assign load_tx = tx_on & ~tx_busy & buf_full & ~sleep_mode;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txbuf <= `AST_RST_ZERO;
			buf_full <= 1'b0;
		end else if (wr_tx) begin
			txbuf <= pwdata[7:0];
			buf_full <= 1'b1;
		end else if (load_tx) begin
			buf_full <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_pend <= 1'b0;
			transmit_enable_q <= 1'b0;
		end else begin
			clr_pend <= wr_tx;
			transmit_enable_q <= txsta.transmit_enable;
		end
	end

	// set wins over the delayed clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_flag <= 1'b0;
		end else if (load_tx | (txsta.transmit_enable & ~transmit_enable_q)) begin
			tx_flag <= 1'b1;
		end else if (clr_pend) begin
			tx_flag <= 1'b0;
		end
	end

	// ==========================================
	// transmit shifter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy <= 1'b0;
			tx_shift <= 11'h7ff;
			tx_bits <= 4'h0;
			tx_ph <= 4'h0;
		end else if (!tx_on) begin
			tx_busy <= 1'b0;
			tx_shift <= 11'h7ff;
			tx_bits <= 4'h0;
			tx_ph <= 4'h0;
		end else if (load_tx) begin
			tx_busy <= 1'b1;
			// no parity of its own: the ninth bit is whatever software put there
			tx_shift <= {1'b1, txsta.tx9 ? txsta.transmit_ninth_bit : 1'b1, txbuf, 1'b0};
			tx_bits <= txsta.tx9 ? `AST_FRAME9 : `AST_FRAME8;
			tx_ph <= 4'h0;
		end else if (tx_busy & s16) begin
			if (tx_ph == `AST_OVS_LAST) begin
				tx_ph <= 4'h0;
				tx_shift <= {1'b1, tx_shift[10:1]};
				tx_bits <= tx_bits - 4'h1;
				if (tx_bits == 4'h1) begin
					tx_busy <= 1'b0;
				end
			end else begin
				tx_ph <= tx_ph + 4'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pin <= 1'b1;
		end else begin
			tx_pin <= tx_busy ? tx_shift[0] : 1'b1;
		end
	end

	// ==========================================
	// receive pin sampling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
			rx_lvl <= 1'b1;
		end else begin
			rx_s1 <= rx_pin;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3) begin
				rx_lvl <= rx_s3;
			end
		end
	end

	// ==========================================
	// receive recovery
	assign rx_done = rx_on & s16 & (rx_state == AST_RX_STOP) & (rx_ph == `AST_OVS_LAST);
	assign rx_over = rc_flag & ~rd_rx;

	// phase starts mid start bit, so each ph wrap lands mid bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= AST_RX_IDLE;
			rx_ph <= 4'h0;
			rx_cnt <= 4'h0;
			rx_sh <= 9'h0;
		end else if (!rx_on) begin
			rx_state <= AST_RX_IDLE;
			rx_ph <= 4'h0;
			rx_cnt <= 4'h0;
		end else if (s16) begin
			unique case (rx_state)
				AST_RX_IDLE: begin
					rx_ph <= 4'h0;
					if (!rx_lvl) begin
						rx_state <= AST_RX_START;
					end
				end
				AST_RX_START: begin
					if (rx_ph == `AST_START_MID) begin
						rx_ph <= 4'h0;
						rx_cnt <= 4'h0;
						// a glitch shorter than half a bit is not a start
						rx_state <= rx_lvl ? AST_RX_IDLE : AST_RX_DATA;
					end else begin
						rx_ph <= rx_ph + 4'h1;
					end
				end
				AST_RX_DATA: begin
					if (rx_ph == `AST_OVS_LAST) begin
						rx_ph <= 4'h0;
						rx_sh <= {rx_lvl, rx_sh[8:1]};
						rx_cnt <= rx_cnt + 4'h1;
						if (rx_cnt == (rcsta.rx9 ? `AST_DATA9_LAST : `AST_DATA8_LAST)) begin
							rx_state <= AST_RX_STOP;
						end
					end else begin
						rx_ph <= rx_ph + 4'h1;
					end
				end
				AST_RX_STOP: begin
					if (rx_ph == `AST_OVS_LAST) begin
						rx_ph <= 4'h0;
						rx_state <= AST_RX_IDLE;
					end else begin
						rx_ph <= rx_ph + 4'h1;
					end
				end
			endcase
		end
	end

	// ==========================================
	// receive results
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxdata <= `AST_RST_ZERO;
			received_ninth_bit <= 1'b0;
			framing_error <= 1'b0;
			overrun_error <= 1'b0;
		end else if (!rcsta.continuous_receive_enable) begin
			framing_error <= 1'b0;
			overrun_error <= 1'b0;
		end else if (rx_done) begin
			if (rx_over) begin
				overrun_error <= 1'b1;
			end else begin
				rxdata <= rcsta.rx9 ? rx_sh[7:0] : rx_sh[8:1];
				received_ninth_bit <= rcsta.rx9 & rx_sh[8];
				framing_error <= ~rx_lvl;
			end
		end
	end

	// set wins over the read that clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_flag <= 1'b0;
		end else if (rx_done & ~rx_over) begin
			rc_flag <= 1'b1;
		end else if (rd_rx) begin
			rc_flag <= 1'b0;
		end
	end

	// ==========================================
	// interrupt request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= interrupt_control[`AST_BIT_GIE] & interrupt_control[`AST_BIT_PERIPHERAL_INTERRUPT_ENABLE] &
				((tx_flag & peripheral_enables_1[`AST_BIT_TXF]) | (rc_flag & peripheral_enables_1[`AST_BIT_RCF]));
		end
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_write_no_load;
		wr_tx && !load_tx ##1 !load_tx && !(txsta.transmit_enable && !transmit_enable_q);
	endsequence

	flag_hold_a: assert property (wr_tx && !load_tx |=> tx_flag == $past(tx_flag))
		else $error("transmit flag changed one cycle after buffer write");
	flag_clear_a: assert property (s_write_no_load |=> !tx_flag)
		else $error("transmit flag not cleared two cycles after write");
	load_flag_a: assert property (load_tx && !wr_tx |=> tx_flag && !buf_full)
		else $error("buffer move did not set flag and empty buffer");
	no_reload_a: assert property (load_tx |-> !tx_busy)
		else $error("shifter reloaded while busy");
	empty_bit_a: assert property (load_tx |=> !txsta_rd.shifter_empty)
		else $error("shifter empty bit set after load");
	transmit_enable_flag_a: assert property ($rose(txsta.transmit_enable) |=> tx_flag)
		else $error("transmit enable did not set flag");
	start_bit_a: assert property (load_tx |-> ##2 !tx_pin)
		else $error("start bit not driven low");
	idle_high_a: assert property (!tx_busy |=> tx_pin)
		else $error("line not idle high");
	lsb_first_a: assert property (tx_busy && s16 && tx_ph == `AST_OVS_LAST && tx_bits > 4'h1
		|=> tx_shift[9:0] == $past(tx_shift[10:1]))
		else $error("transmit shift not lsb first");
	sleep_halt_a: assert property (sleep_mode |-> !s16)
		else $error("sample tick during sleep");
	rx_gate_a: assert property (!rx_on |=> rx_state == AST_RX_IDLE)
		else $error("receiver active while disabled");
	err_clear_a: assert property (!rcsta.continuous_receive_enable |=> !framing_error && !overrun_error)
		else $error("errors kept after receive disabled");
	rx_flag_a: assert property (rx_done |=> rc_flag)
		else $error("receive flag not set at frame end");
	irq_gate_a: assert property (tx_flag && !rc_flag && !peripheral_enables_1[`AST_BIT_TXF] |=> !irq_request)
		else $error("interrupt raised with transmit enable clear");
endmodule : ast_uart
`default_nettype wire

// File: ast_defs.svh
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH
// ==========================================
// register offsets
`define AST_OFF_INTERRUPT_CONTROL 8'h00
`define AST_OFF_PERIPHERAL_FLAGS_1 8'h04
`define AST_OFF_PERIPHERAL_ENABLES_1 8'h08
`define AST_OFF_PERIPHERAL_PRIORITIES_1 8'h0c
`define AST_OFF_PERIPHERAL_FLAGS_3 8'h10
`define AST_OFF_PERIPHERAL_ENABLES_3 8'h14
`define AST_OFF_PERIPHERAL_PRIORITIES_3 8'h18
`define AST_OFF_RCSTA 8'h1c
`define AST_OFF_TXBUF 8'h20
`define AST_OFF_TXSTA 8'h24
`define AST_OFF_BAUD 8'h28
`define AST_OFF_RXDATA 8'h2c
// ==========================================
// reset values
`define AST_RST_ZERO 8'h00
`define AST_RST_PERIPHERAL_PRIORITIES_1 8'h7f
`define AST_RST_PERIPHERAL_PRIORITIES_3 8'h3f
`define AST_RST_TXSTA 8'h02
// ==========================================
// field positions
`define AST_BIT_GIE 7
`define AST_BIT_PERIPHERAL_INTERRUPT_ENABLE 6
`define AST_BIT_RCF 5
`define AST_BIT_TXF 4
`define AST_PERIPHERAL_FLAGS_3_MASK 8'h3f
// ==========================================
// timing counts
`define AST_OVS_LAST 4'hf
`define AST_START_MID 4'h7
`define AST_SLOW_PRE 2'h3
`define AST_FRAME8 4'ha
`define AST_FRAME9 4'hb
`define AST_DATA8_LAST 4'h7
`define AST_DATA9_LAST 4'h8
`endif

// File: ast_pkg.sv
`default_nettype none
package ast_pkg;
	typedef struct packed {
		logic clock_source_select;
		logic tx9;
		logic transmit_enable;
		logic sync;
		logic resv;
		logic high_speed_select;
		logic shifter_empty;
		logic transmit_ninth_bit;
	} ast_txsta_t;
	typedef struct packed {
		logic port_enable;
		logic rx9;
		logic single_receive_enable;
		logic continuous_receive_enable;
		logic address_detect_enable;
		logic framing_error;
		logic overrun_error;
		logic received_ninth_bit;
	} ast_rcsta_t;
	typedef enum logic [1:0] {
		AST_RX_IDLE = 2'b00,
		AST_RX_START = 2'b01,
		AST_RX_DATA = 2'b10,
		AST_RX_STOP = 2'b11
	} ast_rx_state_t;
endpackage : ast_pkg
`default_nettype wire

// File: ast_remote_node.sv
`default_nettype none
module ast_remote_node (
	// clock
	input wire logic pclk,
	// serial line
	input wire logic line_in,
	output logic line_out,
	// frame format
	input wire logic nine
);
	timeunit 1ns;
	timeprecision 1ns;
	int bit_clks = 16;
	int cyc = 0;
	logic [8:0] got[$];
	int starts[$];
	// idle line rests at mark level
	initial line_out = 1'b1;
	always @(posedge pclk) cyc <= cyc + 1;
	// ==========
	// sender, stop level chosen by caller
	task automatic send(input logic [8:0] w, input logic stop);
		int i;
		line_out <= 1'b0;
		repeat (bit_clks) @(posedge pclk);
		for (i = 0; i < (nine ? 9 : 8); i++) begin
			line_out <= w[i];
			repeat (bit_clks) @(posedge pclk);
		end
		line_out <= stop;
		repeat (bit_clks) @(posedge pclk);
		line_out <= 1'b1;
	endtask : send
	// ==========
	// receiver, samples mid bit
	always begin : rx
		int i;
		logic [8:0] w;
		@(negedge line_in);
		starts.push_back(cyc);
		w = '0;
		repeat (bit_clks / 2) @(posedge pclk);
		for (i = 0; i < (nine ? 9 : 8); i++) begin
			repeat (bit_clks) @(posedge pclk);
			w[i] = line_in;
		end
		repeat (bit_clks) @(posedge pclk);
		// frames with a bad stop bit are dropped
		if (line_in === 1'b1) got.push_back(w);
	end
endmodule : ast_remote_node
`default_nettype wire

// File: tb_async_serial_transceiver.sv
`include "ast_defs.svh"
`default_nettype none
module tb_async_serial_transceiver;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sleep_mode = 1'b0;
	logic nine = 1'b0;
	logic rx_pin;
	logic tx_pin;
	logic irq_request;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [31:0] q;
	logic e;
	logic [7:0] ra[12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
		8'h24, 8'h28, 8'h2c};
	logic [7:0] rv[12] = '{8'h00, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00,
		8'h02, 8'h00, 8'h00};
	always #25 pclk = ~pclk;
	ast_uart i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_mode(sleep_mode), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.irq_request(irq_request));
	ast_remote_node i_node (.pclk(pclk), .line_in(tx_pin), .line_out(rx_pin), .nine(nine));
	// ==========
	// verdict and checks
	task automatic close_out;
		if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic fail;
		n_mismatch++;
		$display("ERROR %0t wait timed out", $time);
		close_out();
	endtask : fail
	// ==========
	// apb master; one idle edge after each transfer keeps drives apart
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] r, output logic er);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) fail();
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00, q, e);
		check(q, {24'h0, x});
	endtask : rd
	task automatic wait_rx(input int n);
		int i;
		for (i = 0; i < 3000 && i_node.got.size() < n; i++) @(posedge pclk);
		if (i_node.got.size() < n) fail();
	endtask : wait_rx
	task automatic wait_rxf;
		int n;
		q = '0;
		for (n = 0; n < 200 && q[5] !== 1'b1; n++) apb(1'b0, `AST_OFF_PERIPHERAL_FLAGS_1, 8'h00, q, e);
		if (q[5] !== 1'b1) fail();
	endtask : wait_rxf
	task automatic gotv(input int k, input logic [8:0] x);
		check({23'h0, i_node.got[k]}, {23'h0, x});
	endtask : gotv
	// ==========
	// main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ra[i]) rd(ra[i], rv[i]);
		apb(1'b0, 8'h30, 8'h00, q, e);
		check({31'h0, e}, 32'h1);
		wr(`AST_OFF_BAUD, 8'h00);
		wr(`AST_OFF_RCSTA, 8'h80);
		wr(`AST_OFF_TXSTA, 8'h04);
		rd(`AST_OFF_PERIPHERAL_FLAGS_1, 8'h00);
		wr(`AST_OFF_TXSTA, 8'h24);
		rd(`AST_OFF_PERIPHERAL_FLAGS_1, 8'h10);
		wr(`AST_OFF_PERIPHERAL_FLAGS_1, 8'h00);
		rd(`AST_OFF_PERIPHERAL_FLAGS_1, 8'h10);
		wr(`AST_OFF_PERIPHERAL_ENABLES_1, 8'h10);
		wr(`AST_OFF_INTERRUPT_CONTROL, 8'hc0);
		@(posedge pclk);
		check({31'h0, irq_request}, 32'h1);
		wr(`AST_OFF_PERIPHERAL_ENABLES_1, 8'h00);
		@(posedge pclk);
		check({31'h0, irq_request}, 32'h0);
		// back to back frames
		wr(`AST_OFF_TXBUF, 8'ha5);
		wr(`AST_OFF_TXBUF, 8'h3c);
		rd(`AST_OFF_PERIPHERAL_FLAGS_1, 8'h00);
		rd(`AST_OFF_TXSTA, 8'h24);
		wait_rx(2);
		gotv(0, 9'h0a5);
		gotv(1, 9'h03c);
		check(32'(i_node.starts[1] - i_node.starts[0] inside {[160:163]}), 32'h1);
		rd(`AST_OFF_PERIPHERAL_FLAGS_1, 8'h10);
		repeat (200) @(posedge pclk);
		rd(`AST_OFF_TXSTA, 8'h26);
		nine = 1'b1;
		wr(`AST_OFF_TXSTA, 8'h65);
		wr(`AST_OFF_TXBUF, 8'h5a);
		wait_rx(3);
		gotv(2, 9'h15a);
		repeat (40) @(posedge pclk);
		nine = 1'b0;
		// slow divisor, 64 ticks per bit
		wr(`AST_OFF_BAUD, 8'h01);
		wr(`AST_OFF_TXSTA, 8'h20);
		i_node.bit_clks = 128;
		wr(`AST_OFF_TXBUF, 8'h96);
		wait_rx(4);
		gotv(3, 9'h096);
		repeat (300) @(posedge pclk);
		i_node.bit_clks = 16;
		wr(`AST_OFF_BAUD, 8'h00);
		wr(`AST_OFF_TXSTA, 8'h24);
		sleep_mode <= 1'b1;
		wr(`AST_OFF_TXBUF, 8'h77);
		repeat (300) @(posedge pclk);
		check(i_node.got.size(), 32'd4);
		rd(`AST_OFF_TXSTA, 8'h26);
		sleep_mode <= 1'b0;
		wait_rx(5);
		gotv(4, 9'h077);
		repeat (40) @(posedge pclk);
		wr(`AST_OFF_TXSTA, 8'h34);
		wr(`AST_OFF_TXBUF, 8'h12);
		repeat (300) @(posedge pclk);
		check(i_node.got.size(), 32'd5);
		wr(`AST_OFF_TXSTA, 8'h24);
		wait_rx(6);
		gotv(5, 9'h012);
		// receive path
		i_node.send(9'h033, 1'b1);
		repeat (20) @(posedge pclk);
		rd(`AST_OFF_PERIPHERAL_FLAGS_1, 8'h10);
		wr(`AST_OFF_PERIPHERAL_ENABLES_1, 8'h20);
		wr(`AST_OFF_RCSTA, 8'h90);
		i_node.send(9'h0c3, 1'b1);
		wait_rxf();
		check({31'h0, irq_request}, 32'h1);
		rd(`AST_OFF_RCSTA, 8'h90);
		rd(`AST_OFF_RXDATA, 8'hc3);
		rd(`AST_OFF_PERIPHERAL_FLAGS_1, 8'h10);
		wr(`AST_OFF_RCSTA, 8'hd0);
		nine = 1'b1;
		i_node.send(9'h181, 1'b1);
		wait_rxf();
		nine = 1'b0;
		rd(`AST_OFF_RCSTA, 8'hd1);
		rd(`AST_OFF_RXDATA, 8'h81);
		wr(`AST_OFF_RCSTA, 8'h90);
		i_node.send(9'h055, 1'b0);
		wait_rxf();
		rd(`AST_OFF_RCSTA, 8'h94);
		rd(`AST_OFF_RXDATA, 8'h55);
		wr(`AST_OFF_RCSTA, 8'h80);
		rd(`AST_OFF_RCSTA, 8'h80);
		wr(`AST_OFF_RCSTA, 8'h90);
		i_node.send(9'h001, 1'b1);
		i_node.send(9'h002, 1'b1);
		repeat (20) @(posedge pclk);
		rd(`AST_OFF_RCSTA, 8'h92);
		rd(`AST_OFF_RXDATA, 8'h01);
		wr(`AST_OFF_RCSTA, 8'h80);
		rd(`AST_OFF_RCSTA, 8'h80);
		close_out();
	end
endmodule : tb_async_serial_transceiver
`default_nettype wire
